// ==== design/mbpwm_top.sv ====
// Purpose: match based pulse width timer with Wishbone register access
// Assumes: clk is the peripheral clock; inputs are synchronous to clk
// Notes:   match values are shadowed and released in modulation mode
//
// Notes on behaviour
// (R1) 32-bit counter fed by 32-bit prescaler
// (R2) seven match registers compared against the count
// (R3) period match clears counter, sets period
// (R4) single-edge output rises at period match
// (R5) single-edge value zero keeps output low
// (R6) double-edge output: one rise, one fall match
// (R7) six single, three double, or mixed
// (R8) match may let counter run, interrupt optional
// (R9) match may halt counter, interrupt optional
// (R10) match may clear counter, interrupt optional
// (R11) any tick counts; all outputs share rate
// (R12) new match values apply at period start
// (R13) software releases values; old ones stay meanwhile
// (R14) without modulation mode, plain match timer
// (R15) matches act on the tick count equals
`timescale 1ns/1ps
`include "mbpwm_consts.svh"
module mbpwm_top
	import mbpwm_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq_o,
	output logic      [5:0]  pwm_o
);

	mbpwm_cmp_if cmp ();

	logic         ack_reg;
	mbpwm_word_t  dat_reg;
	logic         irq_reg;
	mbpwm_outs_t  pwm_reg;
	mbpwm_outs_t  pwm_next;

	logic         cnt_en_reg;
	logic         cnt_rst_reg;
	logic         pwm_mode_reg;
	mbpwm_word_t  count_reg;
	mbpwm_word_t  prescale_reg;
	mbpwm_word_t  precount_reg;
	logic [13:0]  mctl_reg;
	mbpwm_outs_t  dbl_reg;
	mbpwm_outs_t  out_en_reg;
	mbpwm_mr_t    shadow_reg;
	mbpwm_mr_t    active_reg;
	mbpwm_flags_t release_reg;
	mbpwm_flags_t release_next;
	mbpwm_flags_t stat_reg;
	mbpwm_flags_t stat_next;
	mbpwm_flags_t mask_reg;

	logic         req;
	logic         wr;
	logic         rd;
	logic         tick;
	mbpwm_flags_t hit;
	mbpwm_flags_t rst_sel;
	mbpwm_flags_t stop_sel;
	logic         rst_hit;
	logic         stop_hit;
	logic         xfer;
	mbpwm_flags_t mr_wr;
	mbpwm_word_t  rd_data;

	// byte lane merge of a write into a stored word
	function automatic mbpwm_word_t lane_merge(
		input mbpwm_word_t old_w,
		input mbpwm_word_t new_w,
		input logic [3:0]  sel
	);
		mbpwm_word_t res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// write strobe for one register address
	function automatic logic wr_at(
		input logic       wr_s,
		input logic [7:0] adr,
		input logic [7:0] target
	);
		return wr_s && (adr == target);
	endfunction

	assign req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr  = req && wb_we_i;
	assign rd  = req && !wb_we_i;

	// prescaler wrap gives one counter tick
	assign tick = cnt_en_reg && !cnt_rst_reg
		&& (precount_reg == prescale_reg); // R1 R11

	assign cmp.tick  = tick;
	assign cmp.count = count_reg;
	assign cmp.mr    = active_reg;
	assign hit       = cmp.hit;

	mbpwm_match_bank i_mbpwm_match_bank (
		.bus (cmp.cmp)
	);

	genvar g;
	generate
		for (g = 0; g < `MBPWM_NUM_MATCH; g++) begin : g_sel
			assign rst_sel[g]  = mctl_reg[g*`MBPWM_MCTL_STRIDE
				+ `MBPWM_MCTL_RST];
			assign stop_sel[g] = mctl_reg[g*`MBPWM_MCTL_STRIDE
				+ `MBPWM_MCTL_STOP];
			assign mr_wr[g]    = wr_at(wr, wb_adr_i,
				8'(`MBPWM_ADR_MATCH0 + 4*g));
		end
	endgenerate

	// period match always clears the count in modulation mode
	assign rst_hit  = (|(hit & rst_sel))
		|| (pwm_mode_reg && hit[0]); // R3 R10
	assign stop_hit = |(hit & stop_sel); // R9

	// shadow transfer only at period start, or while held in reset
	assign xfer = pwm_mode_reg
		&& ((tick && hit[0]) || cnt_rst_reg); // R12 R13

	// bus handshake: answer one cycle after the request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dat_reg <= `MBPWM_RST_WORD;
		end else if (rd) begin
			dat_reg <= rd_data;
		end
	end

	// read multiplexer, unmapped addresses read zero
	always_comb begin
		rd_data = `MBPWM_RST_WORD;
		unique case (wb_adr_i)
			`MBPWM_ADR_STAT:     rd_data = 32'(stat_reg);
			`MBPWM_ADR_CTRL: begin
				rd_data[`MBPWM_CTRL_EN]  = cnt_en_reg;
				rd_data[`MBPWM_CTRL_RST] = cnt_rst_reg;
				rd_data[`MBPWM_CTRL_PWM] = pwm_mode_reg;
			end
			`MBPWM_ADR_COUNT:    rd_data = count_reg;
			`MBPWM_ADR_PRESCALE: rd_data = prescale_reg;
			`MBPWM_ADR_PRECOUNT: rd_data = precount_reg;
			`MBPWM_ADR_MATCHCTL: rd_data = 32'(mctl_reg);
			`MBPWM_ADR_OUTCTL: begin
				rd_data[`MBPWM_OCTL_DBL +: 6] = dbl_reg;
				rd_data[`MBPWM_OCTL_ENA +: 6] = out_en_reg;
			end
			`MBPWM_ADR_RELEASE:  rd_data = 32'(release_reg);
			`MBPWM_ADR_MASK:     rd_data = 32'(mask_reg);
			`MBPWM_ADR_OUTSTATE: rd_data = 32'(pwm_reg);
			default: begin
				for (int m = 0; m < `MBPWM_NUM_MATCH; m++) begin
					if (wb_adr_i == 8'(`MBPWM_ADR_MATCH0 + 4*m)) begin
						rd_data = shadow_reg[m];
					end
				end
			end
		endcase
	end

	// control word: enable, hold in reset, modulation mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_en_reg   <= 1'b0;
			cnt_rst_reg  <= 1'b0;
			pwm_mode_reg <= 1'b0;
		end else if (wr_at(wr, wb_adr_i, `MBPWM_ADR_CTRL) && wb_sel_i[0]) begin
			cnt_en_reg   <= wb_dat_i[`MBPWM_CTRL_EN];
			cnt_rst_reg  <= wb_dat_i[`MBPWM_CTRL_RST];
			pwm_mode_reg <= wb_dat_i[`MBPWM_CTRL_PWM]; // R14
		end else if (stop_hit) begin
			cnt_en_reg   <= 1'b0; // R9
		end
	end

	// prescale counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			precount_reg <= `MBPWM_RST_WORD;
		end else if (cnt_rst_reg
			|| wr_at(wr, wb_adr_i, `MBPWM_ADR_PRESCALE)) begin
			precount_reg <= `MBPWM_RST_WORD;
		end else if (cnt_en_reg) begin
			if (precount_reg == prescale_reg) begin
				precount_reg <= `MBPWM_RST_WORD; // R1
			end else begin
				precount_reg <= precount_reg + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale_reg <= `MBPWM_RST_WORD;
		end else if (wr_at(wr, wb_adr_i, `MBPWM_ADR_PRESCALE)) begin
			prescale_reg <= lane_merge(prescale_reg, wb_dat_i, wb_sel_i);
		end
	end

	// main counter; a clearing match wins over the increment
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= `MBPWM_RST_WORD;
		end else if (wr_at(wr, wb_adr_i, `MBPWM_ADR_COUNT)) begin
			count_reg <= lane_merge(count_reg, wb_dat_i, wb_sel_i);
		end else if (cnt_rst_reg) begin
			count_reg <= `MBPWM_RST_WORD;
		end else if (tick) begin
			if (rst_hit) begin
				count_reg <= `MBPWM_RST_WORD; // R3 R10 R15
			end else begin
				count_reg <= count_reg + 32'h0000_0001; // R8
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mctl_reg <= `MBPWM_RST_MCTL;
		end else if (wr_at(wr, wb_adr_i, `MBPWM_ADR_MATCHCTL)) begin
			mctl_reg <= 14'(lane_merge(32'(mctl_reg), wb_dat_i, wb_sel_i));
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dbl_reg    <= `MBPWM_RST_OUTS;
			out_en_reg <= `MBPWM_RST_OUTS;
		end else if (wr_at(wr, wb_adr_i, `MBPWM_ADR_OUTCTL)) begin
			if (wb_sel_i[0]) begin
				dbl_reg <= wb_dat_i[`MBPWM_OCTL_DBL +: 6] & 6'h3E; // R7
			end
			if (wb_sel_i[1]) begin
				out_en_reg <= wb_dat_i[`MBPWM_OCTL_ENA +: 6];
			end
		end
	end

	// shadow holds written values; active is what the bank compares
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shadow_reg <= '0;
		end else begin
			for (int m = 0; m < `MBPWM_NUM_MATCH; m++) begin
				if (mr_wr[m]) begin
					shadow_reg[m] <= lane_merge(shadow_reg[m], wb_dat_i,
						wb_sel_i);
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_reg <= '0;
		end else begin
			for (int m = 0; m < `MBPWM_NUM_MATCH; m++) begin
				if (!pwm_mode_reg && mr_wr[m]) begin
					active_reg[m] <= lane_merge(shadow_reg[m], wb_dat_i,
						wb_sel_i); // R14
				end else if (xfer && release_reg[m]) begin
					active_reg[m] <= shadow_reg[m]; // R12 R13
				end
			end
		end
	end

	// release bits: a new release beats the clear of a transfer
	always_comb begin
		release_next = release_reg;
		if (xfer) begin
			release_next = `MBPWM_RST_FLAGS; // R13
		end
		if (wr_at(wr, wb_adr_i, `MBPWM_ADR_RELEASE) && wb_sel_i[0]) begin
			release_next = release_next | wb_dat_i[6:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			release_reg <= `MBPWM_RST_FLAGS;
		end else begin
			release_reg <= release_next;
		end
	end

	// sticky match flags, write one to clear, a new match wins
	always_comb begin
		stat_next = stat_reg;
		if (wr_at(wr, wb_adr_i, `MBPWM_ADR_STAT) && wb_sel_i[0]) begin
			stat_next = stat_next & ~wb_dat_i[6:0];
		end
		stat_next = stat_next | hit; // R8 R9 R10
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_reg <= `MBPWM_RST_FLAGS;
		end else begin
			stat_reg <= stat_next;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_reg <= `MBPWM_RST_FLAGS;
		end else if (wr_at(wr, wb_adr_i, `MBPWM_ADR_MASK) && wb_sel_i[0]) begin
			mask_reg <= wb_dat_i[6:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(stat_next & mask_reg); // R8
		end
	end

	// output edges: a fall beats a rise in the same tick
	always_comb begin
		pwm_next = pwm_reg;
		for (int j = 0; j < `MBPWM_NUM_OUT; j++) begin
			if (dbl_reg[j]) begin
				if (hit[j]) begin
					pwm_next[j] = 1'b1; // R6
				end
			end else if (hit[0] && (active_reg[j+1] != '0)) begin
				pwm_next[j] = 1'b1; // R4 R5
			end
			if (hit[j+1]) begin
				pwm_next[j] = 1'b0; // R4 R6 R15
			end
			if (!pwm_mode_reg || !out_en_reg[j]) begin
				pwm_next[j] = 1'b0; // R14
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_reg <= `MBPWM_RST_OUTS;
		end else begin
			pwm_reg <= pwm_next; // R7 R11
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign irq_o    = irq_reg;
	assign pwm_o    = pwm_reg;

endmodule

// ==== design/mbpwm_consts.svh ====
// Purpose: offsets, field positions, reset values and counts of the
//          match based pulse width timer
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes:   every register is one aligned word
`ifndef MBPWM_CONSTS_SVH
`define MBPWM_CONSTS_SVH

`define MBPWM_NUM_MATCH     7
`define MBPWM_NUM_OUT       6

`define MBPWM_ADR_STAT      8'h00
`define MBPWM_ADR_CTRL      8'h04
`define MBPWM_ADR_COUNT     8'h08
`define MBPWM_ADR_PRESCALE  8'h0C
`define MBPWM_ADR_PRECOUNT  8'h10
`define MBPWM_ADR_MATCHCTL  8'h14
`define MBPWM_ADR_MATCH0    8'h18
`define MBPWM_ADR_MATCH1    8'h1C
`define MBPWM_ADR_MATCH2    8'h20
`define MBPWM_ADR_MATCH3    8'h24
`define MBPWM_ADR_MATCH4    8'h28
`define MBPWM_ADR_MATCH5    8'h2C
`define MBPWM_ADR_MATCH6    8'h30
`define MBPWM_ADR_OUTCTL    8'h34
`define MBPWM_ADR_RELEASE   8'h38
`define MBPWM_ADR_MASK      8'h3C
`define MBPWM_ADR_OUTSTATE  8'h40

`define MBPWM_CTRL_EN       0
`define MBPWM_CTRL_RST      1
`define MBPWM_CTRL_PWM      3

`define MBPWM_MCTL_RST      0
`define MBPWM_MCTL_STOP     1
`define MBPWM_MCTL_STRIDE   2
`define MBPWM_MCTL_W        14

`define MBPWM_OCTL_DBL      0
`define MBPWM_OCTL_ENA      8

`define MBPWM_RST_WORD      32'h0000_0000
`define MBPWM_RST_FLAGS     7'h00
`define MBPWM_RST_OUTS      6'h00
`define MBPWM_RST_MCTL      14'h0000

`endif

// ==== design/mbpwm_pkg.sv ====
// Purpose: shared types of the match based pulse width timer
// Assumes: seven match registers of one word each
// Notes:   constants live in mbpwm_consts.svh
package mbpwm_pkg;

	typedef logic [31:0]      mbpwm_word_t;
	typedef logic [6:0][31:0] mbpwm_mr_t;
	typedef logic [6:0]       mbpwm_flags_t;
	typedef logic [5:0]       mbpwm_outs_t;

endpackage

// ==== design/mbpwm_cmp_if.sv ====
// Purpose: carries count, tick and match values to the comparator bank
// Assumes: one clock domain
// Notes:   hit is combinational from the bank
`timescale 1ns/1ps
interface mbpwm_cmp_if;
	import mbpwm_pkg::*;

	logic         tick;
	mbpwm_word_t  count;
	mbpwm_mr_t    mr;
	mbpwm_flags_t hit;

	modport ctrl (output tick, output count, output mr, input hit);
	modport cmp  (input tick, input count, input mr, output hit);

endinterface

// ==== design/mbpwm_match_bank.sv ====
// Purpose: compares the count against the seven active match values
// Assumes: tick marks the counter tick being evaluated
// Notes:   one hit bit for each match register
`timescale 1ns/1ps
`include "mbpwm_consts.svh"
module mbpwm_match_bank
	import mbpwm_pkg::*;
(
	mbpwm_cmp_if.cmp bus
);

	genvar i;
	generate
		for (i = 0; i < `MBPWM_NUM_MATCH; i++) begin : g_cmp
			assign bus.hit[i] = bus.tick && (bus.count == bus.mr[i]); // R2 R15
		end
	endgenerate

endmodule

// ==== dv/mbpwm_chk.sv ====
// Purpose: port checks of the match based pulse width timer
// Assumes: control fields written on lanes 0 and 1
// Notes:   helper registers shadow mode, enables and mask
`timescale 1ns/1ps
`include "mbpwm_consts.svh"
module mbpwm_chk
	import mbpwm_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        irq_o,
	input wire logic [5:0]  pwm_o
);
	logic       take;
	logic       mode_q;
	logic [5:0] ena_q;
	logic [6:0] mask_q;

	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= 1'b0;
			ena_q  <= 6'h00;
			mask_q <= 7'h00;
		end else if (take && wb_we_i) begin
			if (wb_adr_i == `MBPWM_ADR_CTRL && wb_sel_i[0])
				mode_q <= wb_dat_i[`MBPWM_CTRL_PWM];
			if (wb_adr_i == `MBPWM_ADR_OUTCTL && wb_sel_i[1])
				ena_q <= wb_dat_i[13:8];
			if (wb_adr_i == `MBPWM_ADR_MASK && wb_sel_i[0])
				mask_q <= wb_dat_i[6:0];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_ack_answer: assert property (take |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(take))
		else $error("ack without request");
	a_read_hold: assert property (!(take && !wb_we_i) |=> $stable(wb_dat_o))
		else $error("read data moved without read");
	a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i == 8'h80
		|=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_mode_off_quiet: assert property
		(!mode_q && !$past(mode_q) && !$past(mode_q, 2) |-> pwm_o == 6'h00)
		else $error("output active outside modulation mode");
	a_out_disabled: assert property
		((~ena_q & ~$past(ena_q) & ~$past(ena_q, 2) & pwm_o) == 6'h00)
		else $error("disabled output active");
	a_irq_masked: assert property
		(mask_q == 7'h00 && $past(mask_q) == 7'h00 && $past(mask_q, 2) ==
		7'h00 |-> !irq_o)
		else $error("interrupt while fully masked");

	c_read: cover property (take && !wb_we_i);
	c_irq: cover property ($rose(irq_o));
	c_single: cover property (mode_q && $rose(pwm_o[0]));
	c_double: cover property (mode_q && $rose(pwm_o[2]));
endmodule

bind mbpwm_top mbpwm_chk i_mbpwm_chk (
	.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.irq_o(irq_o), .pwm_o(pwm_o)
);

// ==== dv/mbpwm_top_test.sv ====
// Purpose: register level test of the match based pulse width timer
// Assumes: 100 MHz clock, full word accesses apart from one lane 1 count write
// Notes:   output checks count high cycles over whole periods
`timescale 1ns/1ps
`include "mbpwm_consts.svh"
module mbpwm_top_test
	import mbpwm_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'hF;
	mbpwm_word_t wdat = 32'h0000_0000;
	mbpwm_word_t rdat;
	logic        ack;
	logic        irq;
	logic [5:0]  pwm;
	int          n_errors = 0;
	int          comparisons = 0;

	always #5 clk = ~clk;

	mbpwm_top i_mbpwm_top (
		.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .pwm_o(pwm)
	);

	task automatic complete_run;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input string what, input mbpwm_word_t exp,
		input mbpwm_word_t got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input mbpwm_word_t d, output mbpwm_word_t q);
		int n;
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		if (n >= 50)
			check("ack", 32'h1, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input mbpwm_word_t d);
		mbpwm_word_t q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input mbpwm_word_t e,
		input mbpwm_word_t m, input string what);
		mbpwm_word_t q;
		bus(1'b0, a, 32'h0, q);
		check(what, e, q & m);
	endtask

	task automatic measure(input int j, input int e);
		int h;
		h = 0;
		repeat (100) begin
			@(posedge clk);
			if (pwm[j] === 1'b1)
				h++;
			else if (pwm[j] !== 1'b0)
				h += 1000;
		end
		check("high cycles", e, h);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		complete_run();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 17; i++)
			rd(8'(4 * i), 32'h0, 32'hFFFF_FFFF, "reset value");
		check("irq", 32'h0, {31'h0, irq});
		wr(8'h80, 32'hFFFF_FFFF);
		rd(8'h80, 32'h0, 32'hFFFF_FFFF, "unmapped");
		wr(`MBPWM_ADR_PRESCALE, 32'hFFFF_FFFF);
		rd(`MBPWM_ADR_PRESCALE, 32'hFFFF_FFFF, 32'hFFFF_FFFF, "pre");
		wr(`MBPWM_ADR_PRESCALE, 32'h0);
		wr(`MBPWM_ADR_COUNT, 32'h89AB_CDEF);
		rd(`MBPWM_ADR_COUNT, 32'h89AB_CDEF, 32'hFFFF_FFFF, "count");
		sel <= 4'h2;
		wr(`MBPWM_ADR_COUNT, 32'h0000_5500);
		sel <= 4'hF;
		rd(`MBPWM_ADR_COUNT, 32'h89AB_55EF, 32'hFFFF_FFFF, "lane");
		for (int i = 0; i < 7; i++)
			wr(`MBPWM_ADR_MATCH0 + 8'(4 * i), 32'h100 + i);
		for (int i = 0; i < 7; i++)
			rd(`MBPWM_ADR_MATCH0 + 8'(4 * i), 32'h100 + i, 32'hFFFF_FFFF,
				"match");
		wr(`MBPWM_ADR_COUNT, 32'h0);
		wr(`MBPWM_ADR_MATCH2, 32'h1E);
		wr(`MBPWM_ADR_MATCHCTL, 32'h20);
		wr(`MBPWM_ADR_CTRL, 32'h1);
		repeat (60) @(posedge clk);
		rd(`MBPWM_ADR_CTRL, 32'h0, 32'h1, "stop");
		rd(`MBPWM_ADR_STAT, 32'h4, 32'h7F, "stop flag");
		wr(`MBPWM_ADR_STAT, 32'h7F);
		rd(`MBPWM_ADR_STAT, 32'h0, 32'h7F, "flag clear");
		wr(`MBPWM_ADR_MASK, 32'h2);
		wr(`MBPWM_ADR_MATCH1, 32'h5);
		wr(`MBPWM_ADR_MATCHCTL, 32'h4);
		wr(`MBPWM_ADR_COUNT, 32'h0);
		wr(`MBPWM_ADR_CTRL, 32'h1);
		repeat (30) @(posedge clk);
		check("irq", 32'h1, {31'h0, irq});
		rd(`MBPWM_ADR_COUNT, 32'h0, 32'hFFFF_FFF8, "wrap");
		rd(`MBPWM_ADR_STAT, 32'h2, 32'h7F, "clear flag");
		wr(`MBPWM_ADR_CTRL, 32'h0);
		wr(`MBPWM_ADR_STAT, 32'h7F);
		repeat (3) @(posedge clk);
		check("irq", 32'h0, {31'h0, irq});
		wr(`MBPWM_ADR_MATCHCTL, 32'h0);
		wr(`MBPWM_ADR_CTRL, 32'hA);
		rd(`MBPWM_ADR_CTRL, 32'hA, 32'hF, "mode");
		wr(`MBPWM_ADR_MATCH0, 32'h9);
		wr(`MBPWM_ADR_MATCH1, 32'h4);
		wr(`MBPWM_ADR_MATCH2, 32'h2);
		wr(`MBPWM_ADR_MATCH3, 32'h6);
		wr(`MBPWM_ADR_OUTCTL, 32'h504);
		wr(`MBPWM_ADR_RELEASE, 32'h7F);
		wr(`MBPWM_ADR_CTRL, 32'h9);
		repeat (20) @(posedge clk);
		measure(0, 50);
		measure(1, 0);
		measure(2, 40);
		wr(`MBPWM_ADR_MATCH1, 32'h7);
		measure(0, 50);
		wr(`MBPWM_ADR_RELEASE, 32'h2);
		repeat (20) @(posedge clk);
		measure(0, 80);
		measure(2, 40);
		wr(`MBPWM_ADR_MATCH2, 32'h6);
		wr(`MBPWM_ADR_MATCH3, 32'h2);
		wr(`MBPWM_ADR_RELEASE, 32'hC);
		repeat (20) @(posedge clk);
		measure(2, 60);
		wr(`MBPWM_ADR_MATCH1, 32'h0);
		wr(`MBPWM_ADR_RELEASE, 32'h2);
		repeat (20) @(posedge clk);
		measure(0, 0);
		wr(`MBPWM_ADR_CTRL, 32'h1);
		repeat (5) @(posedge clk);
		measure(2, 0);
		wr(`MBPWM_ADR_CTRL, 32'h2);
		wr(`MBPWM_ADR_PRESCALE, 32'h3);
		wr(`MBPWM_ADR_CTRL, 32'h1);
		repeat (40) @(posedge clk);
		wr(`MBPWM_ADR_CTRL, 32'h0);
		rd(`MBPWM_ADR_COUNT, 32'hA, 32'hFFFF_FFFF, "ticks");
		rd(`MBPWM_ADR_PRECOUNT, 32'h3, 32'hFFFF_FFFF, "prescale");
		complete_run();
	end
endmodule
